// *** design/adc_serial_command_decoder.sv ***
// Serial command decoder with register file and result readout
// Operation
// - Offset correction is 24 bits over registers 05h (low) to 07h (high).
// - Full-scale correction is 24 bits over registers 08h (low) to 0Ah (high).
// - Commands are one byte except register read/write with count and data bytes.
// - Output bit order within a byte follows the order configuration bit.
// - Opcodes 00h and FFh both wake: finish sync or leave standby.
// - 01h reads one result, 03h starts continuous, 0Fh stops continuous.
// - F0h to F4h start the five calibration kinds.
// - FCh synchronises, FDh enters standby, FEh resets registers.
// - Count field is number of registers minus one.
// - Host reads after ready falls; ready rises after all 24 bits out.
// - A partial result read leaves ready low, also through the next result, until a full read or calibration start.
// - Continuous mode presents each new result that arrives while idle without further commands.
// - Continuous mode leaves on stop or reset seen in any result byte.
// - Register read returns consecutive registers, wrapping to register zero.
// - Register write stores count plus one bytes from the start address.
// - Calibration kind selects which correction registers are updated.
// - Ready goes high at calibration start, low after settled data.
// - Input bytes MSB first; output bytes most significant byte first.
// - Sync fires on the first clock edge after the wake byte's first serial clock.
// - Reset command restores defaults except clock rate bits, ends continuous mode.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_command_decoder (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        SCLK,
	input  wire logic        DIN,
	input  wire logic        CS_N,
	input  wire logic        CONV_VALID,
	input  wire logic [23:0] CONV_DATA,
	input  wire logic        CAL_DONE,
	input  wire logic [23:0] CAL_OFFSET,
	input  wire logic [23:0] CAL_GAIN,
	output logic             DOUT,
	output logic             DOUT_OE,
	output logic             RESULT_READY_N,
	output logic             CAL_START,
	output logic [2:0]       CAL_KIND,
	output logic             SYNC_PULSE,
	output logic             STANDBY,
	output logic             CONT_MODE,
	output logic [1:0]       CLKOUT_RATE
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		adc_cmd_pkg::state_type st;
		logic [2:0]             bit_cnt;
		logic [7:0]             rx;
		logic [7:0]             tx;
		logic [1:0]             byte_idx;
		logic [3:0]             addr;
		logic [3:0]             cnt;
		logic                   wr;
		logic [10:0][7:0]       regs;
		logic [23:0]            result;
		logic                   result_ready_n_n;
		logic                   cont;
		logic                   sync_pend;
		logic                   standby;
		logic                   dout;
		logic                   sync_pulse;
		logic                   cal_start;
		logic [2:0]             cal_kind;
	} dec_type;

	dec_type s_q;
	dec_type s_d;
	logic    sclk_rise;
	logic    sclk_fall;
	logic    cs_n_rise;
	logic    din_s;
	logic    cs_n_s;
	logic    byte_done;
	logic    cal_cmd;
	logic [7:0] rx_byte;

	// ************************************************************
	// Pin sampling
	// ************************************************************
	link_sampler u_sampler (
		.CLK       (CLK),
		.RST       (RST),
		.sclk_pin  (SCLK),
		.din_pin   (DIN),
		.cs_n_pin  (CS_N),
		.sclk_rise (sclk_rise),
		.sclk_fall (sclk_fall),
		.cs_n_rise (cs_n_rise),
		.din_s     (din_s),
		.cs_n_s    (cs_n_s)
	);

	// Byte assembly, MSB first
	assign rx_byte   = {s_q.rx[6:0], din_s};
	assign byte_done = sclk_fall & ~cs_n_s & (s_q.bit_cnt == 3'd7);
	assign cal_cmd   = (rx_byte[7:3] == adc_cmd_pkg::OP_CAL_PREFIX) &&
		(rx_byte[2:0] <= adc_cmd_pkg::CAL_SYS_GAIN);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Register defaults, clock rate bits kept
	function automatic logic [10:0][7:0] reg_defaults(input logic [10:0][7:0] cur);
		logic [10:0][7:0] r;
		r = '0;
		r[adc_cmd_pkg::REG_STATUS] = adc_cmd_pkg::RST_STATUS;
		r[adc_cmd_pkg::REG_MUX]    = adc_cmd_pkg::RST_MUX;
		r[adc_cmd_pkg::REG_ADCON]  = (adc_cmd_pkg::RST_ADCON & ~adc_cmd_pkg::CLK_RATE_MASK) |
			(cur[adc_cmd_pkg::REG_ADCON] & adc_cmd_pkg::CLK_RATE_MASK);
		r[adc_cmd_pkg::REG_DRATE]  = adc_cmd_pkg::RST_DRATE;
		r[adc_cmd_pkg::REG_IO]     = adc_cmd_pkg::RST_IO;
		for (int i = 5; i < adc_cmd_pkg::NUM_REGS; i++) begin
			r[i] = adc_cmd_pkg::RST_CAL;
		end
		return r;
	endfunction

	// Register read view, status composed live
	function automatic logic [7:0] reg_view(input dec_type s, input logic [3:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == adc_cmd_pkg::REG_STATUS) begin
			v = {adc_cmd_pkg::DEVICE_ID, s.regs[0][3:1], s.result_ready_n_n};
		end else if (a <= adc_cmd_pkg::REG_LAST) begin
			v = s.regs[a];
		end
		return v;
	endfunction

	// Next address with wrap to zero
	function automatic logic [3:0] next_addr(input logic [3:0] a);
		return (a >= adc_cmd_pkg::REG_LAST) ? 4'h0 : a + 4'h1;
	endfunction

	// Result byte, most significant first
	function automatic logic [7:0] result_byte(input logic [23:0] r, input logic [1:0] i);
		logic [7:0] b;
		case (i)
			2'd0: b = r[23:16];
			2'd1: b = r[15:8];
			default: b = r[7:0];
		endcase
		return b;
	endfunction

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.sync_pulse = 1'b0;
		s_d.cal_start  = 1'b0;
		// Drive output bit on the serial rising edge
		if (sclk_rise && !cs_n_s) begin
			s_d.dout = s_q.regs[0][adc_cmd_pkg::ORDER_BIT] ? s_q.tx[s_q.bit_cnt] :
				s_q.tx[3'd7 - s_q.bit_cnt];
		end
		// First serial clock after a sync command
		if (sclk_rise && !cs_n_s && s_q.sync_pend && s_q.bit_cnt == 3'd0 &&
			s_q.st == adc_cmd_pkg::ST_IDLE) begin
			s_d.sync_pulse = 1'b1;
			s_d.sync_pend  = 1'b0;
		end
		// Shift in on the falling edge
		if (sclk_fall && !cs_n_s) begin
			s_d.rx      = rx_byte;
			s_d.bit_cnt = s_q.bit_cnt + 3'd1;
		end
		// Chip select high frames the byte counter
		if (cs_n_s) begin
			s_d.bit_cnt = 3'd0;
		end
		// Deselect abandons a sequence except calibration; ready keeps its level
		if (cs_n_rise && s_q.st != adc_cmd_pkg::ST_CAL) begin
			s_d.st = adc_cmd_pkg::ST_IDLE;
		end
		// New conversion result
		if (CONV_VALID && s_q.st == adc_cmd_pkg::ST_IDLE) begin
			s_d.result = CONV_DATA;
			s_d.result_ready_n_n = 1'b0;
			if (s_q.cont) begin
				s_d.st       = adc_cmd_pkg::ST_READ;
				s_d.byte_idx = 2'd0;
				s_d.tx       = CONV_DATA[23:16];
			end
		end
		// Calibration completion
		if (s_q.st == adc_cmd_pkg::ST_CAL && CAL_DONE) begin
			s_d.st = adc_cmd_pkg::ST_IDLE;
			if (s_q.cal_kind != adc_cmd_pkg::CAL_SELF_GAIN &&
				s_q.cal_kind != adc_cmd_pkg::CAL_SYS_GAIN) begin
				s_d.regs[adc_cmd_pkg::REG_OFC_LOW]  = CAL_OFFSET[7:0];
				s_d.regs[adc_cmd_pkg::REG_OFC_MID]  = CAL_OFFSET[15:8];
				s_d.regs[adc_cmd_pkg::REG_OFC_HIGH] = CAL_OFFSET[23:16];
			end
			if (s_q.cal_kind == adc_cmd_pkg::CAL_FULL ||
				s_q.cal_kind == adc_cmd_pkg::CAL_SELF_GAIN ||
				s_q.cal_kind == adc_cmd_pkg::CAL_SYS_GAIN) begin
				s_d.regs[adc_cmd_pkg::REG_FSC_LOW]  = CAL_GAIN[7:0];
				s_d.regs[adc_cmd_pkg::REG_FSC_MID]  = CAL_GAIN[15:8];
				s_d.regs[adc_cmd_pkg::REG_FSC_HIGH] = CAL_GAIN[23:16];
			end
		end
		// Completed byte
		if (byte_done) begin
			case (s_q.st)
				adc_cmd_pkg::ST_IDLE: begin
					if (s_q.cont) begin
						if (rx_byte == adc_cmd_pkg::OP_STOP) begin
							s_d.cont = 1'b0;
						end else if (rx_byte == adc_cmd_pkg::OP_RESET) begin
							s_d.cont = 1'b0;
							s_d.regs = reg_defaults(s_q.regs);
						end
					end else if (rx_byte == adc_cmd_pkg::OP_WAKE_LOW ||
						rx_byte == adc_cmd_pkg::OP_WAKE_HIGH) begin
						s_d.standby   = 1'b0;
						s_d.sync_pend = 1'b0;
					end else if (rx_byte == adc_cmd_pkg::OP_READ) begin
						s_d.st       = adc_cmd_pkg::ST_READ;
						s_d.byte_idx = 2'd0;
						s_d.tx       = s_q.result[23:16];
					end else if (rx_byte == adc_cmd_pkg::OP_CONT) begin
						s_d.cont = 1'b1;
					end else if (rx_byte == adc_cmd_pkg::OP_STOP) begin
						s_d.cont = 1'b0;
					end else if (cal_cmd) begin
						s_d.st        = adc_cmd_pkg::ST_CAL;
						s_d.result_ready_n_n    = 1'b1;
						s_d.cal_start = 1'b1;
						s_d.cal_kind  = rx_byte[2:0];
					end else if (rx_byte == adc_cmd_pkg::OP_SYNC) begin
						s_d.sync_pend = 1'b1;
					end else if (rx_byte == adc_cmd_pkg::OP_STANDBY) begin
						s_d.standby = 1'b1;
					end else if (rx_byte == adc_cmd_pkg::OP_RESET) begin
						s_d.regs = reg_defaults(s_q.regs);
						s_d.cont = 1'b0;
					end else if (rx_byte[7:4] == adc_cmd_pkg::OP_REGISTER_READ_CMD_NIB ||
						rx_byte[7:4] == adc_cmd_pkg::OP_REGISTER_WRITE_CMD_NIB) begin
						s_d.st   = adc_cmd_pkg::ST_COUNT;
						s_d.addr = rx_byte[3:0];
						s_d.wr   = (rx_byte[7:4] == adc_cmd_pkg::OP_REGISTER_WRITE_CMD_NIB);
					end
					// Any other byte falls through untouched
				end
				adc_cmd_pkg::ST_COUNT: begin
					s_d.cnt = rx_byte[3:0];
					s_d.st  = s_q.wr ? adc_cmd_pkg::ST_REGISTER_WRITE_CMD : adc_cmd_pkg::ST_REGISTER_READ_CMD;
					s_d.tx  = reg_view(s_q, s_q.addr);
				end
				adc_cmd_pkg::ST_REGISTER_READ_CMD, adc_cmd_pkg::ST_REGISTER_WRITE_CMD: begin
					if (s_q.st == adc_cmd_pkg::ST_REGISTER_WRITE_CMD) begin
						if (s_q.addr == adc_cmd_pkg::REG_STATUS) begin
							s_d.regs[0] = rx_byte & ~adc_cmd_pkg::STATUS_RO;
						end else if (s_q.addr == adc_cmd_pkg::REG_ADCON) begin
							s_d.regs[2] = rx_byte & ~adc_cmd_pkg::ADCON_RO;
						end else if (s_q.addr <= adc_cmd_pkg::REG_LAST) begin
							s_d.regs[s_q.addr] = rx_byte;
						end
					end
					s_d.addr = next_addr(s_q.addr);
					s_d.tx   = reg_view(s_q, next_addr(s_q.addr));
					s_d.cnt  = s_q.cnt - 4'h1;
					if (s_q.cnt == 4'h0) begin
						s_d.st = adc_cmd_pkg::ST_IDLE;
					end
				end
				adc_cmd_pkg::ST_READ: begin
					if (s_q.cont && rx_byte == adc_cmd_pkg::OP_STOP) begin
						s_d.cont = 1'b0;
					end else if (s_q.cont && rx_byte == adc_cmd_pkg::OP_RESET) begin
						s_d.cont = 1'b0;
						s_d.regs = reg_defaults(s_q.regs);
					end
					s_d.byte_idx = s_q.byte_idx + 2'd1;
					s_d.tx       = result_byte(s_q.result, s_q.byte_idx + 2'd1);
					if (s_q.byte_idx == adc_cmd_pkg::RESULT_LAST) begin
						s_d.result_ready_n_n = 1'b1;
						s_d.st     = adc_cmd_pkg::ST_IDLE;
					end
				end
				adc_cmd_pkg::ST_CAL: begin
					s_d.st = s_q.st;
				end
				default: begin
					s_d.st = adc_cmd_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q        <= '0;
			s_q.st     <= adc_cmd_pkg::ST_IDLE;
			s_q.result_ready_n_n <= 1'b1;
			s_q.regs   <= reg_defaults('0);
			s_q.regs[adc_cmd_pkg::REG_ADCON] <= adc_cmd_pkg::RST_ADCON;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign DOUT           = s_q.dout;
	assign DOUT_OE        = ~cs_n_s;
	assign RESULT_READY_N = s_q.result_ready_n_n;
	assign CAL_START      = s_q.cal_start;
	assign CAL_KIND       = s_q.cal_kind;
	assign SYNC_PULSE     = s_q.sync_pulse;
	assign STANDBY        = s_q.standby;
	assign CONT_MODE      = s_q.cont;
	assign CLKOUT_RATE    = s_q.regs[2][adc_cmd_pkg::CLK_RATE_HI:adc_cmd_pkg::CLK_RATE_LO];

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence cmd_seq(logic [7:0] op);
		s_q.st == adc_cmd_pkg::ST_IDLE && !s_q.cont && byte_done && rx_byte == op;
	endsequence
	sequence last_result_byte;
		s_q.st == adc_cmd_pkg::ST_READ && byte_done && s_q.byte_idx == 2'd2;
	endsequence

	AST_STANDBY_ENTER: assert property (cmd_seq(adc_cmd_pkg::OP_STANDBY) |=> STANDBY)
		else $error("standby not entered");
	AST_WAKE_LEAVES: assert property (
		STANDBY ##0 cmd_seq(adc_cmd_pkg::OP_WAKE_HIGH) |=> !STANDBY)
		else $error("wake did not leave standby");
	AST_READ_START: assert property (
		cmd_seq(adc_cmd_pkg::OP_READ)
		|=> s_q.st == adc_cmd_pkg::ST_READ && s_q.byte_idx == 2'd0)
		else $error("single read not started");
	AST_CAL_RESULT_READY_N: assert property (
		s_q.st == adc_cmd_pkg::ST_IDLE && !s_q.cont && byte_done &&
		cal_cmd |=> RESULT_READY_N && CAL_START ##1 !CAL_START)
		else $error("calibration start not signalled");
	AST_CAL_HOLD: assert property (s_q.st == adc_cmd_pkg::ST_CAL |-> RESULT_READY_N)
		else $error("ready fell during calibration");
	AST_GAIN_ONLY: assert property (
		s_q.st == adc_cmd_pkg::ST_CAL && CAL_DONE &&
		s_q.cal_kind == adc_cmd_pkg::CAL_SELF_GAIN |=> $stable(s_q.regs[7:5]) &&
		s_q.regs[8] == $past(CAL_GAIN[7:0]))
		else $error("gain calibration touched offset");
	AST_RESULT_READY_N_AFTER_24: assert property (
		last_result_byte |=> RESULT_READY_N && s_q.st == adc_cmd_pkg::ST_IDLE)
		else $error("ready not raised after result");
	AST_CONT_STOP: assert property (
		CONT_MODE && s_q.st == adc_cmd_pkg::ST_READ && byte_done &&
		rx_byte == adc_cmd_pkg::OP_STOP |=> !CONT_MODE)
		else $error("continuous mode not stopped");
	AST_CONT_LAUNCH: assert property (
		CONT_MODE && s_q.st == adc_cmd_pkg::ST_IDLE &&
		CONV_VALID && !byte_done && !cs_n_rise |=> s_q.st == adc_cmd_pkg::ST_READ &&
		!RESULT_READY_N)
		else $error("continuous result not presented");
	AST_UNKNOWN: assert property (
		cmd_seq(8'h20) && !CONV_VALID |=> $stable(s_q.regs) &&
		$stable(CONT_MODE) && s_q.st == adc_cmd_pkg::ST_IDLE)
		else $error("unknown opcode changed state");
	AST_SYNC_EDGE: assert property (
		s_q.sync_pend && s_q.st == adc_cmd_pkg::ST_IDLE &&
		sclk_rise && !cs_n_s && s_q.bit_cnt == 3'd0 |=> SYNC_PULSE ##1 !SYNC_PULSE)
		else $error("sync not fired on first serial clock");
	// Reset opcode acts whether or not continuous mode is on
	AST_RESET_CMD: assert property (
		s_q.st == adc_cmd_pkg::ST_IDLE && byte_done &&
		rx_byte == adc_cmd_pkg::OP_RESET |=> !CONT_MODE &&
		$stable(CLKOUT_RATE) && s_q.regs[3] == adc_cmd_pkg::RST_DRATE)
		else $error("reset command wrong");

endmodule // adc_serial_command_decoder
`default_nettype wire

// *** design/adc_cmd_pkg.sv ***
// Shared constants and types for the serial command decoder
`default_nettype none
package adc_cmd_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int unsigned NUM_REGS    = 11;
	localparam logic [3:0] REG_STATUS   = 4'h0;
	localparam logic [3:0] REG_MUX      = 4'h1;
	localparam logic [3:0] REG_ADCON    = 4'h2;
	localparam logic [3:0] REG_DRATE    = 4'h3;
	localparam logic [3:0] REG_IO       = 4'h4;
	localparam logic [3:0] REG_OFC_LOW  = 4'h5;
	localparam logic [3:0] REG_OFC_MID  = 4'h6;
	localparam logic [3:0] REG_OFC_HIGH = 4'h7;
	localparam logic [3:0] REG_FSC_LOW  = 4'h8;
	localparam logic [3:0] REG_FSC_MID  = 4'h9;
	localparam logic [3:0] REG_FSC_HIGH = 4'ha;
	localparam logic [3:0] REG_LAST     = 4'ha;

	// ************************************************************
	// Reset values and fields
	// ************************************************************
	localparam logic [7:0] RST_STATUS   = 8'h00;
	localparam logic [7:0] RST_MUX      = 8'h01;
	localparam logic [7:0] RST_ADCON    = 8'h20;
	localparam logic [7:0] RST_DRATE    = 8'hf0;
	localparam logic [7:0] RST_IO       = 8'he0;
	localparam logic [7:0] RST_CAL      = 8'h00;
	localparam logic [3:0] DEVICE_ID    = 4'h3; // Arbitrary value
	localparam int unsigned ORDER_BIT   = 3;
	localparam int unsigned CLK_RATE_LO = 5;
	localparam int unsigned CLK_RATE_HI = 6;
	localparam logic [7:0] STATUS_RO   = 8'hf1;
	localparam logic [7:0] ADCON_RO    = 8'h80;
	localparam logic [7:0] CLK_RATE_MASK = 8'h60;

	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_WAKE_LOW   = 8'h00;
	localparam logic [7:0] OP_READ       = 8'h01;
	localparam logic [7:0] OP_CONT       = 8'h03;
	localparam logic [7:0] OP_STOP       = 8'h0f;
	localparam logic [3:0] OP_REGISTER_READ_CMD_NIB   = 4'h1;
	localparam logic [3:0] OP_REGISTER_WRITE_CMD_NIB   = 4'h5;
	localparam logic [4:0] OP_CAL_PREFIX = 5'h1e;
	localparam logic [2:0] CAL_FULL      = 3'h0;
	localparam logic [2:0] CAL_SELF_OFS  = 3'h1;
	localparam logic [2:0] CAL_SELF_GAIN = 3'h2;
	localparam logic [2:0] CAL_SYS_OFS   = 3'h3;
	localparam logic [2:0] CAL_SYS_GAIN  = 3'h4;
	localparam logic [7:0] OP_SYNC       = 8'hfc;
	localparam logic [7:0] OP_STANDBY    = 8'hfd;
	localparam logic [7:0] OP_RESET      = 8'hfe;
	localparam logic [7:0] OP_WAKE_HIGH  = 8'hff;
	localparam logic [1:0] RESULT_LAST   = 2'd2;

	// ************************************************************
	// Decoder states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_COUNT,
		ST_REGISTER_READ_CMD,
		ST_REGISTER_WRITE_CMD,
		ST_READ,
		ST_CAL
	} state_type;

endpackage
`default_nettype wire

// *** design/link_sampler.sv ***
// Two-stage synchronisers and edge finders for the serial link pins
`timescale 1ns/100ps
`default_nettype none
module link_sampler (
	input  wire logic CLK,
	input  wire logic RST,
	input  wire logic sclk_pin,
	input  wire logic din_pin,
	input  wire logic cs_n_pin,
	output logic      sclk_rise,
	output logic      sclk_fall,
	output logic      cs_n_rise,
	output logic      din_s,
	output logic      cs_n_s
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic sclk_meta;
		logic sclk_s;
		logic sclk_d;
		logic din_meta;
		logic din_s;
		logic cs_meta;
		logic cs_s;
		logic cs_d;
	} samp_type;

	samp_type s_q;
	samp_type s_d;

	// Meta flops feed only the second stage
	always_comb begin
		s_d = s_q;
		s_d.sclk_meta = sclk_pin;
		s_d.sclk_s    = s_q.sclk_meta;
		s_d.sclk_d    = s_q.sclk_s;
		s_d.din_meta  = din_pin;
		s_d.din_s     = s_q.din_meta;
		s_d.cs_meta   = cs_n_pin;
		s_d.cs_s      = s_q.cs_meta;
		s_d.cs_d      = s_q.cs_s;
	end

	// Chip select idles high
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= '{default: 1'b0, cs_meta: 1'b1, cs_s: 1'b1, cs_d: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// Edge pulses from the settled stages
	assign sclk_rise = s_q.sclk_s & ~s_q.sclk_d;
	assign sclk_fall = ~s_q.sclk_s & s_q.sclk_d;
	assign cs_n_rise = s_q.cs_s & ~s_q.cs_d;
	assign din_s     = s_q.din_s;
	assign cs_n_s    = s_q.cs_s;

endmodule // link_sampler
`default_nettype wire

// *** testbench/spi_host.sv ***
// Serial host model driving the command link
`timescale 1ns/100ps
`default_nettype none
module spi_host (
	output logic      SCLK,
	output logic      DIN,
	output logic      CS_N,
	input  wire logic DOUT
);
	// ************************************************************
	// Idle link: clock low, deselected
	// ************************************************************
	initial begin
		SCLK = 1'b0;
		DIN = 1'b1;
		CS_N = 1'b1;
	end

	// Select, held through the whole sequence
	task automatic sel();
		CS_N = 1'b0;
		#100;
	endtask

	// Release; a released line shows no stale value
	task automatic desel();
		#100;
		CS_N = 1'b1;
		DIN = ~DIN;
		#200;
	endtask

	// One byte, MSB first, output sampled on the falling clock
	// Data in changes mid-low so it never races the falling edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			#40 DIN = tx[i];
			#40 SCLK = 1'b1;
			#80 SCLK = 1'b0;
			rx[i] = DOUT;
		end
		#100;
	endtask
endmodule // spi_host
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the serial command decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic        clk, rst, sclk, din, cs_n, cv, cal_done, dout, rdy_n, cal_start;
	logic        sync_pulse, standby, cont_mode, dout_oe;
	logic [23:0] cdata, coff, cgain, d;
	logic [2:0]  cal_kind;
	logic [1:0]  rate;
	logic [7:0]  rx;
	logic [7:0]  q[$];
	int          fail_count, cmp_count, syncs, cals, m[11];

	// ************************************************************
	// Clock, instances, pulse counters
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) syncs <= syncs + int'(sync_pulse === 1'b1);
	always @(posedge clk) cals <= cals + int'(cal_start === 1'b1);
	spi_host h (.SCLK(sclk), .DIN(din), .CS_N(cs_n), .DOUT(dout));
	adc_serial_command_decoder u_dut (.CLK(clk), .RST(rst), .SCLK(sclk), .DIN(din),
		.CS_N(cs_n), .CONV_VALID(cv), .CONV_DATA(cdata), .CAL_DONE(cal_done),
		.CAL_OFFSET(coff), .CAL_GAIN(cgain), .DOUT(dout), .DOUT_OE(dout_oe),
		.RESULT_READY_N(rdy_n), .CAL_START(cal_start), .CAL_KIND(cal_kind),
		.SYNC_PULSE(sync_pulse), .STANDBY(standby), .CONT_MODE(cont_mode),
		.CLKOUT_RATE(rate));

	// ************************************************************
	// Model helpers and link tasks
	// ************************************************************
	function automatic logic [7:0] ob(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = v[7 - i];
		return m[0][3] ? r : v;
	endfunction
	task automatic cmd(input logic [7:0] op);
		h.sel();
		h.xfer(op, rx);
		h.desel();
	endtask
	task automatic register_read_cmd(input int a, input int n);
		logic [7:0] e;
		h.sel();
		h.xfer(8'h10 | 8'(a), rx);
		h.xfer(8'(n - 1), rx);
		for (int i = 0; i < n; i++) begin
			e = (a + i) % 11 == 0 ? {adc_cmd_pkg::DEVICE_ID, m[0][3:1], rdy_n} : 8'(m[(a + i) % 11]);
			h.xfer(8'h00, rx);
			`CHK(rx, ob(e))
		end
		`CHK(dout_oe, 1'b1)
		h.desel();
	endtask
	task automatic register_write_cmd(input int a, input logic [7:0] v[$]);
		int r;
		h.sel();
		h.xfer(8'h50 | 8'(a), rx);
		h.xfer(8'(v.size() - 1), rx);
		foreach (v[i]) begin
			h.xfer(v[i], rx);
			r = (a + i) % 11;
			m[r] = r == 0 ? v[i] & 8'h0e : r == 2 ? v[i] & 8'h7f : v[i];
		end
		h.desel();
	endtask
	task automatic conv(input logic [23:0] v);
		@(posedge clk);
		#1 cv = 1'b1;
		cdata = v;
		@(posedge clk);
		#1 cv = 1'b0;
	endtask
	task automatic wrdy(input logic v);
		int k;
		k = 0;
		while (rdy_n !== v && k < 4000) begin
			@(posedge clk);
			#1 k++;
		end
		if (k == 4000) begin
			$display("BAD %0t ready wait timed out", $time);
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic rdres(input logic [23:0] v, input logic [7:0] op);
		for (int i = 2; i >= 0; i--) begin
			h.xfer(i == 0 ? op : 8'h00, rx);
			`CHK(rx, ob(v[8 * i +: 8]))
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		cv = 1'b0;
		cal_done = 1'b0;
		{cdata, coff, cgain} = '0;
		m = '{8'h00, 8'h01, 8'h20, 8'hf0, 8'he0, 0, 0, 0, 0, 0, 0};
		void'($urandom(39));
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		register_read_cmd(0, 11);
		for (int i = 0; i < 6; i++) q.push_back(8'($urandom));
		register_write_cmd(5, q);
		register_read_cmd(9, 4);
		register_write_cmd(2, '{8'hc0});
		`CHK(rate, 2'b10)
		// Partial read, refresh, then full read in both bit orders
		for (int o = 0; o < 2; o++) begin
			register_write_cmd(0, '{8'(o << 3)});
			conv(24'($urandom));
			wrdy(1'b0);
			h.sel();
			h.xfer(8'h01, rx);
			h.xfer(8'h00, rx);
			h.desel();
			`CHK(rdy_n, 1'b0)
			d = 24'($urandom);
			conv(d);
			h.sel();
			h.xfer(8'h01, rx);
			rdres(d, 8'h00);
			h.desel();
			`CHK(rdy_n, 1'b1)
		end
		// All five calibration kinds
		for (int k = 0; k < 5; k++) begin
			cmd(8'hf0 | 8'(k));
			`CHK(cal_kind, 3'(k))
			`CHK(rdy_n, 1'b1)
			@(posedge clk);
			#1 cal_done = 1'b1;
			coff = 24'($urandom);
			cgain = 24'($urandom);
			@(posedge clk);
			#1 cal_done = 1'b0;
			repeat (4) @(posedge clk);
			`CHK(rdy_n, 1'b1)
			conv(24'h0);
			wrdy(1'b0);
			for (int b = 0; b < 3; b++) begin
				if (k != 2 && k != 4) m[5 + b] = coff[8 * b +: 8];
				if (k == 0 || k == 2 || k == 4) m[8 + b] = cgain[8 * b +: 8];
			end
			register_read_cmd(5, 6);
		end
		`CHK(cals, 5)
		// Continuous readout, stop seen in the last byte
		cmd(8'h03);
		for (int k = 0; k < 2; k++) begin
			d = 24'($urandom);
			conv(d);
			wrdy(1'b0);
			h.sel();
			rdres(d, k ? 8'h0f : 8'h00);
			h.desel();
		end
		`CHK(cont_mode, 1'b0)
		// Sync, standby with both wake codes, reset in continuous mode
		h.sel();
		h.xfer(8'hfc, rx);
		h.xfer(8'h00, rx);
		h.desel();
		`CHK(syncs, 1)
		foreach (q[i]) q[i] = i[0] ? 8'hff : 8'h00;
		for (int k = 0; k < 2; k++) begin
			cmd(8'hfd);
			`CHK(standby, 1'b1)
			cmd(q[k]);
			`CHK(standby, 1'b0)
		end
		cmd(8'h03);
		`CHK(cont_mode, 1'b1)
		cmd(8'hfe);
		`CHK(cont_mode, 1'b0)
		m = '{8'h00, 8'h01, 8'h40, 8'hf0, 8'he0, 0, 0, 0, 0, 0, 0};
		cmd(8'h77);
		cmd(8'h20);
		register_read_cmd(0, 11);
		// Pin reset in mid-run brings the clock rate bits back
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		`CHK(rate, 2'b01)
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
